// ### design/dps_consts.svh
/*
  offsets, field positions, reset value and timing counts of the
  dual pin function select block.
  assumes a 40 MHz core clock and the 16-bit configuration map.
*/
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

`define DPS_CFG_MMS        4'hC
`define DPS_CFG_ADDR       16'h0012
`define DPS_CFG_RESET      16'h4040

`define DPS_B_SLEW1        15
`define DPS_B_PULLEN1      14
`define DPS_B_PULLDN1      13
`define DPS_B_FN1_HI       12
`define DPS_B_FN1_LO       9
`define DPS_B_PIN_ONE_LEVEL_POLARITY         8
`define DPS_B_SLEW0        7
`define DPS_B_PULLEN0      6
`define DPS_B_PULLDN0      5
`define DPS_B_FN0_HI       4
`define DPS_B_FN0_LO       1
`define DPS_B_PIN_ZERO_LEVEL_POLARITY         0

`define DPS_CLK_NS         25
`define DPS_SFD_PULSE_NS   100
`define DPS_SFD_PULSE_CYC  ((`DPS_SFD_PULSE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_ACT_HOLD_NS    10000
`define DPS_ACT_HOLD_CYC   ((`DPS_ACT_HOLD_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)

`endif

// ### design/dps_pin_drive.sv
/*
  output selector for one auxiliary pin: picks the source that the
  function code names, applies polarity, registers level and enable.
  assumes all event inputs are already in the clk domain.
*/
module dps_pin_drive (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] fn_sel,
  input  wire logic       level_pol,
  input  wire logic       frame_start_transmit_pulse_pulse,
  input  wire logic       sfd_any_pulse,
  input  wire logic       link_led,
  input  wire logic       plca_led,
  input  wire logic       tx_led,
  input  wire logic       any_led,
  input  wire logic       clk25_lvl,
  output logic            pin_out_ff,
  output logic            pin_oe_ff
);

  wire logic src_w;
  wire logic known_w;
  wire logic nxt_out;
  wire logic nxt_oe;

  // reserved codes fall to known_w = 0 and leave the pin floating
  assign src_w =
    (fn_sel == dps_pkg::DPS_FN_FRAME_START_TRANSMIT_PULSE)  ? frame_start_transmit_pulse_pulse  :
    (fn_sel == dps_pkg::DPS_FN_FRAME_START_RECEIVE_PULSE)  ? sfd_any_pulse :
    (fn_sel == dps_pkg::DPS_FN_LED_LNK) ? link_led      :
    (fn_sel == dps_pkg::DPS_FN_LED_PLC) ? plca_led      :
    (fn_sel == dps_pkg::DPS_FN_LED_TX)  ? tx_led        :
    (fn_sel == dps_pkg::DPS_FN_LED_RX)  ? any_led       :
    (fn_sel == dps_pkg::DPS_FN_SFD_ANY) ? sfd_any_pulse :
    (fn_sel == dps_pkg::DPS_FN_LED_ANY) ? any_led       :
    (fn_sel == dps_pkg::DPS_FN_CLK25)   ? clk25_lvl     :
    1'b0;

  assign known_w = (fn_sel <= 4'h8) || (fn_sel == 4'hB) ||
                   (fn_sel == 4'hF);
  assign nxt_oe  = known_w && (fn_sel != dps_pkg::DPS_FN_HIZ);
  assign nxt_out = (fn_sel == dps_pkg::DPS_FN_GPIO) ? level_pol :
                   (level_pol ? src_w : ~src_w);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff  <= 1'b0;
    end else begin
      pin_out_ff <= nxt_out;
      pin_oe_ff  <= nxt_oe;
    end
  end

  hiz_release_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h0 |=> !pin_oe_ff)
    else $error("pin driven while function is off");

  gpio_level_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h1 |=> pin_oe_ff && pin_out_ff == $past(level_pol))
    else $error("general output level wrong");

  frame_start_transmit_pulse_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h2 && frame_start_transmit_pulse_pulse |=> pin_out_ff == $past(level_pol))
    else $error("transmit delimiter pulse missing");

  frame_start_receive_pulse_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h3 |=> pin_out_ff == ($past(sfd_any_pulse) ~^
                                      $past(level_pol)))
    else $error("receive delimiter pulse wrong");

  link_led_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h4 |=> pin_out_ff == ($past(link_led) ~^
                                      $past(level_pol)))
    else $error("link led wrong");

  plca_led_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h5 |=> pin_out_ff == ($past(plca_led) ~^
                                      $past(level_pol)))
    else $error("plca led wrong");

  tx_led_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h6 && !tx_led && level_pol |=> !pin_out_ff)
    else $error("transmit led lit without activity");

  rx_led_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'h7 && any_led && !level_pol |=> !pin_out_ff)
    else $error("receive led not lit active low");

  sfd_any_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_sel == 4'hB && sfd_any_pulse && level_pol |=> pin_out_ff)
    else $error("any delimiter pulse missing");

  reserved_hiz_a: assert property (
    @(posedge clk) disable iff (rst)
    (fn_sel inside {4'h9, 4'hA, 4'hC, 4'hD, 4'hE}) |=> !pin_oe_ff)
    else $error("reserved code drives the pin");

endmodule : dps_pin_drive

// ### design/dps_pkg.sv
/*
  types of the dual pin function select block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package dps_pkg;

  typedef enum logic [3:0] {
    DPS_FN_HIZ     = 4'h0,
    DPS_FN_GPIO    = 4'h1,
    DPS_FN_FRAME_START_TRANSMIT_PULSE  = 4'h2,
    DPS_FN_FRAME_START_RECEIVE_PULSE  = 4'h3,
    DPS_FN_LED_LNK = 4'h4,
    DPS_FN_LED_PLC = 4'h5,
    DPS_FN_LED_TX  = 4'h6,
    DPS_FN_LED_RX  = 4'h7,
    DPS_FN_CLK25   = 4'h8,
    DPS_FN_SFD_ANY = 4'hB,
    DPS_FN_LED_ANY = 4'hF
  } dps_fn_e;

  typedef logic [15:0] dps_cfg_t;

endpackage : dps_pkg

// ### design/dps_top.sv
/*
  dual pin function select: the 16-bit pin configuration register in
  map 12, event stretchers, clock level sync and two pin selectors.
  assumes register strobes and event strobes come from logic on clk;
  the 25 MHz clock level arrives from another domain.
*/
`include "dps_consts.svh"

//
// Contract
// - each pin has its own four-bit function code, pin one at 12:9 and pin zero at 4:1, driving that pin.
// - code 0x0 leaves the pin floating, and that is the state after reset.
// - code 0x1 makes the pin a general output following its value bit.
// - code 0x2 pulses the pin on each transmitted frame start delimiter, polarity from the value bit.
// - code 0x3 pulses the pin on each received delimiter, and transmitted ones too, polarity from the value bit.
// - code 0x4 lights the led only while the port is enabled and link is up.
// - code 0x5 lights the led while collision avoidance status is up.
// - code 0x6 lights the led on transmit activity.
// - code 0x7 lights the led on receive activity, and transmit activity too.
// - code 0xB pulses the pin on every delimiter sent or received, polarity from the value bit.
// - code 0xF shows combined activity, 0x8 gives the 25 MHz clock, and reserved codes must not be used.
// - the value bit (8 and 0) is the level in output mode and the polarity in every other mode.
// - the slew bit (15 and 7) selects slow edges when one and fast when zero.
// - pull enable bits (14 and 6) and pull type bits (13 and 5) select pull-down on one, pull-up on zero.
// - the register is a 16-bit entry at 0x0012 of map 12 reached over the serial configuration port.
module dps_top #(
  parameter int SFD_PULSE_CYC = `DPS_SFD_PULSE_CYC,
  parameter int ACT_HOLD_CYC  = `DPS_ACT_HOLD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [3:0]  cfg_mms,
  input  wire logic [15:0] cfg_addr,
  input  wire logic [15:0] cfg_wdata,
  output logic [15:0]      cfg_rdata_ff,
  input  wire logic        frame_start_transmit_pulse,
  input  wire logic        frame_start_receive_pulse,
  input  wire logic        port_en,
  input  wire logic        link_up,
  input  wire logic        plca_up,
  input  wire logic        tx_act,
  input  wire logic        rx_act,
  input  wire logic        clk25_in,
  output logic             aux_pin_one_out,
  output logic             aux_pin_one_oe,
  output logic             aux_pin_zero_out,
  output logic             aux_pin_zero_oe,
  output logic             pin_one_slew_slow_ff,
  output logic             pin_one_pull_en_ff,
  output logic             pin_one_pull_down_ff,
  output logic             pin_zero_slew_slow_ff,
  output logic             pin_zero_pull_en_ff,
  output logic             pin_zero_pull_down_ff
);

  localparam int CW = $clog2(ACT_HOLD_CYC + SFD_PULSE_CYC + 1);
  localparam logic [CW-1:0] SFD_LEN = CW'(SFD_PULSE_CYC);
  localparam logic [CW-1:0] ACT_LEN = CW'(ACT_HOLD_CYC);

  // reload on an event, otherwise count down to zero
  function automatic logic [CW-1:0] dps_stretch(
    input logic          ev,
    input logic [CW-1:0] cnt,
    input logic [CW-1:0] len
  );
    if (ev) begin
      return len;
    end
    return (cnt == '0) ? cnt : cnt - CW'(1);
  endfunction : dps_stretch

  dps_pkg::dps_cfg_t cfg_reg_ff;
  logic [CW-1:0]     frame_start_transmit_pulse_cnt_ff;
  logic [CW-1:0]     sfd_any_cnt_ff;
  logic [CW-1:0]     act_tx_cnt_ff;
  logic [CW-1:0]     act_any_cnt_ff;
  logic              clk25_s1_ff;
  logic              clk25_s2_ff;
  logic              clk25_s3_ff;
  logic              clk25_lvl_ff;

  wire logic          cfg_hit_w;
  wire logic          cfg_wr_hit_w;
  wire logic [15:0]   nxt_rdata;
  wire logic          sfd_any_ev_w;
  wire logic          act_any_ev_w;
  wire logic          frame_start_transmit_pulse_on_w;
  wire logic          sfd_any_on_w;
  wire logic          act_tx_on_w;
  wire logic          act_any_on_w;
  wire logic          link_led_w;
  wire logic          nxt_clk25_lvl;
  wire logic [3:0]    fn_one_w;
  wire logic [3:0]    fn_zero_w;

  assign cfg_hit_w    = (cfg_mms == `DPS_CFG_MMS) &&
                        (cfg_addr == `DPS_CFG_ADDR);
  assign cfg_wr_hit_w = cfg_wr && cfg_hit_w;
  assign nxt_rdata    = cfg_hit_w ? cfg_reg_ff : 16'h0000;

  // a transmitted delimiter also counts as a received one
  assign sfd_any_ev_w = frame_start_receive_pulse | frame_start_transmit_pulse;
  assign act_any_ev_w = rx_act | tx_act;
  assign frame_start_transmit_pulse_on_w  = frame_start_transmit_pulse_cnt_ff != '0;
  assign sfd_any_on_w = sfd_any_cnt_ff != '0;
  assign act_tx_on_w  = act_tx_cnt_ff != '0;
  assign act_any_on_w = act_any_cnt_ff != '0;
  assign link_led_w   = port_en & link_up;

  assign nxt_clk25_lvl = (clk25_s2_ff == clk25_s3_ff) ? clk25_s3_ff
                                                      : clk25_lvl_ff;

  assign fn_one_w  = cfg_reg_ff[`DPS_B_FN1_HI:`DPS_B_FN1_LO];
  assign fn_zero_w = cfg_reg_ff[`DPS_B_FN0_HI:`DPS_B_FN0_LO];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg_ff   <= `DPS_CFG_RESET;
      cfg_rdata_ff <= 16'h0000;
    end else begin
      if (cfg_wr_hit_w) begin
        cfg_reg_ff <= cfg_wdata;
      end
      if (cfg_rd) begin
        cfg_rdata_ff <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_start_transmit_pulse_cnt_ff  <= '0;
      sfd_any_cnt_ff <= '0;
      act_tx_cnt_ff  <= '0;
      act_any_cnt_ff <= '0;
    end else begin
      frame_start_transmit_pulse_cnt_ff  <= dps_stretch(frame_start_transmit_pulse, frame_start_transmit_pulse_cnt_ff, SFD_LEN);
      sfd_any_cnt_ff <= dps_stretch(sfd_any_ev_w, sfd_any_cnt_ff, SFD_LEN);
      act_tx_cnt_ff  <= dps_stretch(tx_act, act_tx_cnt_ff, ACT_LEN);
      act_any_cnt_ff <= dps_stretch(act_any_ev_w, act_any_cnt_ff, ACT_LEN);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk25_s1_ff  <= 1'b0;
      clk25_s2_ff  <= 1'b0;
      clk25_s3_ff  <= 1'b0;
      clk25_lvl_ff <= 1'b0;
    end else begin
      clk25_s1_ff  <= clk25_in;
      clk25_s2_ff  <= clk25_s1_ff;
      clk25_s3_ff  <= clk25_s2_ff;
      clk25_lvl_ff <= nxt_clk25_lvl;
    end
  end

  // pad controls are copied so they change two cycles after the write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_one_slew_slow_ff  <= 1'b0;
      pin_one_pull_en_ff    <= 1'b0;
      pin_one_pull_down_ff  <= 1'b0;
      pin_zero_slew_slow_ff <= 1'b0;
      pin_zero_pull_en_ff   <= 1'b0;
      pin_zero_pull_down_ff <= 1'b0;
    end else begin
      pin_one_slew_slow_ff  <= cfg_reg_ff[`DPS_B_SLEW1];
      pin_one_pull_en_ff    <= cfg_reg_ff[`DPS_B_PULLEN1];
      pin_one_pull_down_ff  <= cfg_reg_ff[`DPS_B_PULLDN1];
      pin_zero_slew_slow_ff <= cfg_reg_ff[`DPS_B_SLEW0];
      pin_zero_pull_en_ff   <= cfg_reg_ff[`DPS_B_PULLEN0];
      pin_zero_pull_down_ff <= cfg_reg_ff[`DPS_B_PULLDN0];
    end
  end

  dps_pin_drive u_pin_one (
    .clk           (clk),
    .rst           (rst),
    .fn_sel        (fn_one_w),
    .level_pol     (cfg_reg_ff[`DPS_B_PIN_ONE_LEVEL_POLARITY]),
    .frame_start_transmit_pulse_pulse  (frame_start_transmit_pulse_on_w),
    .sfd_any_pulse (sfd_any_on_w),
    .link_led      (link_led_w),
    .plca_led      (plca_up),
    .tx_led        (act_tx_on_w),
    .any_led       (act_any_on_w),
    .clk25_lvl     (clk25_lvl_ff),
    .pin_out_ff    (aux_pin_one_out),
    .pin_oe_ff     (aux_pin_one_oe)
  );

  dps_pin_drive u_pin_zero (
    .clk           (clk),
    .rst           (rst),
    .fn_sel        (fn_zero_w),
    .level_pol     (cfg_reg_ff[`DPS_B_PIN_ZERO_LEVEL_POLARITY]),
    .frame_start_transmit_pulse_pulse  (frame_start_transmit_pulse_on_w),
    .sfd_any_pulse (sfd_any_on_w),
    .link_led      (link_led_w),
    .plca_led      (plca_up),
    .tx_led        (act_tx_on_w),
    .any_led       (act_any_on_w),
    .clk25_lvl     (clk25_lvl_ff),
    .pin_out_ff    (aux_pin_zero_out),
    .pin_oe_ff     (aux_pin_zero_oe)
  );

  reg_write_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w |=> cfg_reg_ff == $past(cfg_wdata))
    else $error("register write not stored");

  reg_unmapped_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr && !cfg_hit_w |=> $stable(cfg_reg_ff))
    else $error("unmapped write changed the register");

  slew_follow_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w |-> ##2 pin_one_slew_slow_ff == $past(cfg_wdata[15], 2)
                      && pin_zero_slew_slow_ff == $past(cfg_wdata[7], 2))
    else $error("slew control not applied");

  pull_follow_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w |-> ##2 pin_one_pull_down_ff == $past(cfg_wdata[13], 2)
                      && pin_zero_pull_en_ff == $past(cfg_wdata[6], 2))
    else $error("pull control not applied");

  fn_settle_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w && cfg_wdata[12:9] == 4'h1 |-> ##2
      aux_pin_one_oe && aux_pin_one_out == $past(cfg_wdata[8], 2))
    else $error("new function not on pin two cycles after write");

  fn_zero_hiz_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w && cfg_wdata[4:1] == 4'h0 |-> ##2 !aux_pin_zero_oe)
    else $error("pin zero driven after disable");

  sfd_stretch_a: assert property (
    @(posedge clk) disable iff (rst)
    frame_start_transmit_pulse |=> frame_start_transmit_pulse_on_w [*4])
    else $error("delimiter pulse shorter than its width");

  act_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    tx_act |=> act_any_on_w [*8])
    else $error("activity led not held");

  tx_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    tx_act |=> act_tx_on_w [*8])
    else $error("transmit led not held");

  rx_stretch_a: assert property (
    @(posedge clk) disable iff (rst)
    frame_start_receive_pulse |=> sfd_any_on_w [*4])
    else $error("receive delimiter pulse too short");

  sfd_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !frame_start_transmit_pulse && !frame_start_transmit_pulse_on_w |=> !frame_start_transmit_pulse_on_w)
    else $error("delimiter pulse without a delimiter");

  act_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !act_any_ev_w && !act_any_on_w |=> !act_any_on_w)
    else $error("activity led lit without activity");

  read_data_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_rd && cfg_hit_w |=> cfg_rdata_ff == $past(cfg_reg_ff))
    else $error("read data differs from the register");

  read_unmapped_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_rd && !cfg_hit_w |=> cfg_rdata_ff == 16'h0000)
    else $error("unmapped read not zero");

  read_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !cfg_rd |=> $stable(cfg_rdata_ff))
    else $error("read data changed without a read");

  pad_copy_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w |-> ##2
      pin_one_pull_en_ff == $past(cfg_wdata[`DPS_B_PULLEN1], 2) &&
      pin_zero_pull_down_ff == $past(cfg_wdata[`DPS_B_PULLDN0], 2))
    else $error("pull control not copied");

  fn_one_hiz_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w && cfg_wdata[12:9] == 4'h0 |-> ##2 !aux_pin_one_oe)
    else $error("pin one driven after disable");

  fn_zero_gpio_a: assert property (
    @(posedge clk) disable iff (rst)
    cfg_wr_hit_w && cfg_wdata[4:1] == 4'h1 |-> ##2
      aux_pin_zero_oe && aux_pin_zero_out == $past(cfg_wdata[0], 2))
    else $error("pin zero output not set two cycles after write");

  clk_out_a: assert property (
    @(posedge clk) disable iff (rst)
    fn_one_w == 4'h8 && cfg_reg_ff[`DPS_B_PIN_ONE_LEVEL_POLARITY] |=>
      aux_pin_one_out == $past(clk25_lvl_ff))
    else $error("clock not passed to pin one");

endmodule : dps_top

// ### verif/dps_pin_observer.sv
/*
  pad model of one auxiliary pin as a led or outside logic sees it.
  assumes the pad falls to its pull resistor whenever it is not driven and its pull is enabled.
*/
module dps_pin_observer (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pull_en,
  input  wire logic pull_down,
  output logic      pad
);
  timeunit 1ns;
  timeprecision 100ps;

  logic churn_ff = 1'b0;

  // an undriven, unpulled pad wanders instead of keeping a level
  always @(posedge clk) churn_ff <= ~churn_ff;

  assign pad = pin_oe ? pin_out : (pull_en ? ~pull_down : churn_ff);
endmodule : dps_pin_observer

// ### verif/dps_top_tb.sv
/*
  self-checking bench of the dual pin function select block.
  assumes dps_top on a 40 MHz clock with a shortened activity hold count.
*/
module dps_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SFD_CYC = 4;
  localparam int ACT_CYC = 8;

  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        cfg_wr     = 1'b0;
  logic        cfg_rd     = 1'b0;
  logic [3:0]  cfg_mms    = 4'h0;
  logic [15:0] cfg_addr   = 16'h0000;
  logic [15:0] cfg_wdata  = 16'h0000;
  logic [3:0]  ev         = 4'h0;
  logic        port_en    = 1'b0;
  logic        link_up    = 1'b0;
  logic        plca_up    = 1'b0;
  logic        clk25_in   = 1'b0;
  logic [15:0] cfg        = 16'h4040;
  logic        rd_d       = 1'b0;
  logic [15:0] rdata;
  logic        o1, e1, o0, e0, pad1, pad0;
  logic        s1, p1, d1, s0, p0, d0;
  logic [15:0] rq [$];
  logic [9:0]  pq [$];
  logic [3:0]  rsv [6]    = '{4'h0, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE};
  logic [3:0]  evc [6]    = '{4'h2, 4'h3, 4'hB, 4'h6, 4'h7, 4'hF};
  int          seed       = 74092;
  int          fail_count = 0;
  int          compares   = 0;

  always #12.5 clk = ~clk;
  always #20 clk25_in = ~clk25_in;

  dps_top #(.SFD_PULSE_CYC(SFD_CYC), .ACT_HOLD_CYC(ACT_CYC)) i_dps_top (
    .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_mms(cfg_mms), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata_ff(rdata), .frame_start_transmit_pulse(ev[0]), .frame_start_receive_pulse(ev[1]),
    .port_en(port_en), .link_up(link_up), .plca_up(plca_up),
    .tx_act(ev[2]), .rx_act(ev[3]), .clk25_in(clk25_in),
    .aux_pin_one_out(o1), .aux_pin_one_oe(e1),
    .aux_pin_zero_out(o0), .aux_pin_zero_oe(e0),
    .pin_one_slew_slow_ff(s1), .pin_one_pull_en_ff(p1),
    .pin_one_pull_down_ff(d1), .pin_zero_slew_slow_ff(s0),
    .pin_zero_pull_en_ff(p0), .pin_zero_pull_down_ff(d0));

  dps_pin_observer i_obs_one (.clk(clk), .pin_out(o1), .pin_oe(e1),
    .pull_en(p1), .pull_down(d1), .pad(pad1));
  dps_pin_observer i_obs_zero (.clk(clk), .pin_out(o0), .pin_oe(e0),
    .pull_en(p0), .pull_down(d0), .pad(pad0));

  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_pin(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: pins %b expected %b", $time, got, exp);
    end
  endtask : cmp_pin

  always @(posedge clk) rd_d <= cfg_rd;

  always @(negedge clk) begin
    if (rd_d) cmp_rd(rdata, rq.pop_front());
    if (pq.size() > 0) cmp_pin({e1, pad1, e0, pad0, s1, p1, d1, s0, p0, d0},
                               pq.pop_front());
  end

  task automatic exp_pins(input logic x1, input logic y1,
                          input logic x0, input logic y0);
    pq.push_back({x1, x1 ? y1 : ~cfg[13], x0, x0 ? y0 : ~cfg[5],
                  cfg[15:13], cfg[7:5]});
  endtask : exp_pins

  task automatic bus(input logic w, input logic r, input logic [3:0] m,
                     input logic [15:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    @(posedge clk);
    cfg_wr    <= w;
    cfg_rd    <= r;
    cfg_mms   <= m;
    cfg_addr  <= a;
    cfg_wdata <= d;
    if (r) rq.push_back(e);
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
  endtask : bus

  task automatic pins(input logic [3:0] c1, input logic v1,
                      input logic [3:0] c0, input logic v0);
    logic [15:0] r;
    r = $random(seed);
    cfg = (r & 16'hA0A0) | 16'h4040 | {3'h0, c1, v1, 3'h0, c0, v0};
    bus(1'b1, 1'b0, 4'hC, 16'h0012, cfg, 16'h0000);
    repeat (2) @(posedge clk);
  endtask : pins

  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  initial begin
    logic v;
    logic act;
    logic p;
    int   n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    exp_pins(1'b0, 1'b0, 1'b0, 1'b0);
    bus(1'b0, 1'b1, 4'hC, 16'h0012, 16'h0000, 16'h4040);
    bus(1'b1, 1'b0, 4'hB, 16'h0012, 16'hFFFF, 16'h0000);
    bus(1'b1, 1'b0, 4'hC, 16'h0013, 16'hFFFF, 16'h0000);
    bus(1'b0, 1'b1, 4'hC, 16'h0013, 16'h0000, 16'h0000);
    bus(1'b1, 1'b1, 4'hC, 16'h0012, 16'h0202, 16'h4040);
    cfg = 16'h0202;
    bus(1'b0, 1'b1, 4'hC, 16'h0012, 16'h0000, 16'h0202);
    for (int i = 0; i < 4; i++) begin
      pins(4'h1, i[1], 4'h1, i[0]);
      exp_pins(1'b1, i[1], 1'b1, i[0]);
      bus(1'b0, 1'b1, 4'hC, 16'h0012, 16'h0000, cfg);
    end
    foreach (rsv[k]) begin
      pins(rsv[k], 1'b1, rsv[k], 1'b0);
      exp_pins(1'b0, 1'b0, 1'b0, 1'b0);
    end
    v = $random(seed);
    pins(4'h4, v, 4'h5, ~v);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {port_en, link_up, plca_up} <= i[2:0];
      repeat (2) @(posedge clk);
      exp_pins(1'b1, (i[2] & i[1]) ~^ v, 1'b1, i[0] ~^ ~v);
    end
    foreach (evc[k]) begin
      v = $random(seed);
      pins(evc[k], ~v, evc[k], v);
      n = (evc[k] inside {4'h2, 4'h3, 4'hB}) ? SFD_CYC : ACT_CYC;
      for (int e = 0; e < 2; e++) begin
        act = (e == 0) || !(evc[k] inside {4'h2, 4'h6});
        @(posedge clk);
        ev <= (n == SFD_CYC ? 4'h1 : 4'h4) << e;
        @(posedge clk);
        ev <= 4'h0;
        repeat (2) @(posedge clk);
        exp_pins(1'b1, act ~^ ~v, 1'b1, act ~^ v);
        repeat (n - 2) @(posedge clk);
        exp_pins(1'b1, act ~^ ~v, 1'b1, act ~^ v);
        @(posedge clk);
        exp_pins(1'b1, v, 1'b1, ~v);
      end
    end
    pins(4'h8, 1'b1, 4'h8, 1'b0);
    n = 0;
    p = o0;
    repeat (40) begin
      @(negedge clk);
      if (o0 !== p) n++;
      p = o0;
    end
    cmp_rd({14'h0000, e1, e0}, 16'h0003);
    // the synchronised 25 MHz level changes about every fourth cycle
    cmp_rd(16'(n >= 8 && n <= 12), 16'h0001);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule : dps_top_tb
